// >>> hdl/serial_irq_counter_port_regs.sv
`timescale 1ns/1ns
`default_nettype none
module serial_irq_counter_port_regs import serial_regs_pkg::*; #(
  parameter int unsigned INPUT_COUNT = 3
) (
  // clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  // processor bus
  input  wire logic [31:0]   cpu_addr_i,
  input  wire logic          cpu_rd_i,
  input  wire logic          cpu_wr_i,
  input  wire logic [15:0]   cpu_wdata_i,
  output logic      [15:0]   cpu_rdata_o,
  // channels
  input  wire chan_status_t  chan_a_i,
  input  wire chan_status_t  chan_b_i,
  output logic               tx_load_a_o,
  output logic               tx_load_b_o,
  // channel clocks for output functions
  input  wire logic          chan_a_transmit_clock16_i,
  input  wire logic          chan_a_transmit_clock_i,
  input  wire logic          chan_a_receive_clock_i,
  input  wire logic          chan_b_transmit_clock_i,
  input  wire logic          chan_b_receive_clock_i,
  // counter/timer core
  output counter_ctl_t       ctr_ctl_o,
  input  wire logic [15:0]   ctr_count_i,
  input  wire logic          ctr_out_i,
  input  wire logic          ctr_terminal_i,
  // port pins
  input  wire logic [INPUT_COUNT-1:0] general_inputs_i,
  output logic      [1:0]    output_pins_o,
  output logic               general_output_2_o,
  output logic               general_output_3_o,
  output logic               general_output_3_oe_o,
  // interrupt
  output logic               irq_o,
  output logic      [7:0]    irq_vector_o
);

  if (INPUT_COUNT != 3) begin : g_bad_inputs
    $error("serial_irq_counter_port_regs: INPUT_COUNT must be 3");
  end

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
    hit = (addr == ofs);
  endfunction

  // only the low data byte carries information; the upper byte is ignored
  logic [7:0] wbyte;
  assign wbyte = cpu_wdata_i[7:0];

  logic rd_change, rd_flags, rd_cnt_hi, rd_cnt_lo, rd_vec, rd_pins, rd_start, rd_stop;
  logic wr_aux, wr_enable, wr_pre_hi, wr_pre_lo, wr_vec, wr_func, wr_set, wr_clear;

  always_comb begin
    rd_change = cpu_rd_i && hit(cpu_addr_i, OFS_CHANGE_AUX);
    rd_flags  = cpu_rd_i && hit(cpu_addr_i, OFS_FLAGS_ENABLE);
    rd_cnt_hi = cpu_rd_i && hit(cpu_addr_i, OFS_COUNT_HI);
    rd_cnt_lo = cpu_rd_i && hit(cpu_addr_i, OFS_COUNT_LO);
    rd_vec    = cpu_rd_i && hit(cpu_addr_i, OFS_VECTOR);
    rd_pins   = cpu_rd_i && hit(cpu_addr_i, OFS_PINS_FUNC);
    rd_start  = cpu_rd_i && hit(cpu_addr_i, OFS_START_SET);
    rd_stop   = cpu_rd_i && hit(cpu_addr_i, OFS_STOP);
    wr_aux    = cpu_wr_i && hit(cpu_addr_i, OFS_CHANGE_AUX);
    wr_enable = cpu_wr_i && hit(cpu_addr_i, OFS_FLAGS_ENABLE);
    wr_pre_hi = cpu_wr_i && hit(cpu_addr_i, OFS_COUNT_HI);
    wr_pre_lo = cpu_wr_i && hit(cpu_addr_i, OFS_COUNT_LO);
    wr_vec    = cpu_wr_i && hit(cpu_addr_i, OFS_VECTOR);
    wr_func   = cpu_wr_i && hit(cpu_addr_i, OFS_PINS_FUNC);
    wr_set    = cpu_wr_i && hit(cpu_addr_i, OFS_START_SET);
    wr_clear  = cpu_wr_i && hit(cpu_addr_i, OFS_OUT_CLEAR);
  end

  // input change detection
  logic [2:0] in_level, in_change, in_pulse;

  input_change_detect #(
    .N (INPUT_COUNT)
  ) u_detect (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .levels_i       (general_inputs_i),
    .clear_i        (rd_change),
    .level_o        (in_level),
    .change_o       (in_change),
    .change_pulse_o (in_pulse)
  );

  // software control registers
  logic [7:0]  aux_ctrl_r;
  logic [7:0]  enables_r;
  logic [15:0] preload_r;
  logic [7:0]  vector_r;
  logic [7:0]  func_r;
  logic [7:0]  op_bits_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aux_ctrl_r <= REG_ZERO;
      enables_r  <= REG_ZERO;
      func_r     <= REG_ZERO;
    end else begin
      if (wr_aux) aux_ctrl_r <= wbyte;
      if (wr_enable) enables_r <= wbyte;
      if (wr_func) func_r <= wbyte;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      preload_r <= {REG_ZERO, REG_ZERO};
    end else begin
      if (wr_pre_hi) preload_r[15:8] <= wbyte;
      if (wr_pre_lo) preload_r[7:0] <= wbyte;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vector_r <= VECTOR_RESET;
    end else if (wr_vec) begin
      vector_r <= wbyte;
    end
  end

  // set and clear are separate addresses, so at most one acts per cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      op_bits_r <= REG_ZERO;
    end else if (wr_set) begin
      op_bits_r <= op_bits_r | wbyte;
    end else if (wr_clear) begin
      op_bits_r <= op_bits_r & ~wbyte;
    end
  end

  // sticky status; a setting event wins over a clear in the same cycle
  logic cos_r, brk_a_r, brk_b_r, ctr_rdy_r;
  logic cos_set;

  assign cos_set = |(in_pulse & aux_ctrl_r[2:0]);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cos_r     <= 1'b0;
      brk_a_r   <= 1'b0;
      brk_b_r   <= 1'b0;
      ctr_rdy_r <= 1'b0;
    end else begin
      cos_r     <= (cos_r && !rd_change) || cos_set;
      brk_a_r   <= (brk_a_r && !chan_a_i.break_clear) || chan_a_i.break_edge;
      brk_b_r   <= (brk_b_r && !chan_b_i.break_clear) || chan_b_i.break_edge;
      ctr_rdy_r <= (ctr_rdy_r && !rd_stop) || ctr_terminal_i;
    end
  end

  logic [7:0] flags_w;

  always_comb begin
    flags_w            = REG_ZERO;
    flags_w[BIT_COS]   = cos_r;
    flags_w[BIT_BRK_B] = brk_b_r;
    flags_w[BIT_RX_B]  = chan_b_i.full_select ? chan_b_i.fifo_full : chan_b_i.receive_ready;
    flags_w[BIT_TX_B]  = chan_b_i.transmit_ready;
    flags_w[BIT_CTR]   = ctr_rdy_r;
    flags_w[BIT_BRK_A] = brk_a_r;
    flags_w[BIT_RX_A]  = chan_a_i.full_select ? chan_a_i.fifo_full : chan_a_i.receive_ready;
    flags_w[BIT_TX_A]  = chan_a_i.transmit_ready;
  end

  // a holding write while not ready never reaches the transmitter
  assign tx_load_a_o = chan_a_i.holding_write && chan_a_i.transmit_ready;
  assign tx_load_b_o = chan_b_i.holding_write && chan_b_i.transmit_ready;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_w & enables_r);
    end
  end

  assign irq_vector_o = vector_r;

  // counter/timer commands go out one cycle after the read strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctr_ctl_o <= '0;
    end else begin
      ctr_ctl_o.start       <= rd_start;
      ctr_ctl_o.stop        <= rd_stop;
      ctr_ctl_o.mode_source <= aux_ctrl_r[AUX_CTMS_LSB +: 3];
      ctr_ctl_o.preload     <= preload_r;
    end
  end

  // read data; count is passed through live, so it is only coherent when stopped
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cpu_rdata_o <= '0;
    end else if (cpu_rd_i) begin
      cpu_rdata_o[15:8] <= REG_ZERO;
      if (rd_change) begin
        cpu_rdata_o[7:0] <= {1'b0, in_change, 1'b0, in_level};
      end else if (rd_flags) begin
        cpu_rdata_o[7:0] <= flags_w;
      end else if (rd_cnt_hi) begin
        cpu_rdata_o[7:0] <= ctr_count_i[15:8];
      end else if (rd_cnt_lo) begin
        cpu_rdata_o[7:0] <= ctr_count_i[7:0];
      end else if (rd_vec) begin
        cpu_rdata_o[7:0] <= vector_r;
      end else if (rd_pins) begin
        cpu_rdata_o[7:0] <= {2'b00, UPPER_INPUTS, general_inputs_i};
      end else begin
        cpu_rdata_o[7:0] <= REG_ZERO;
      end
    end
  end

  out_port_drive u_drive (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .op_bits_i (op_bits_r[3:0]),
    .out3_fn_i (func_r[OUT3_FN_LSB +: 2]),
    .out2_fn_i (func_r[OUT2_FN_LSB +: 2]),
    .ctr_out_i (ctr_out_i),
    .a_tx16_i  (chan_a_transmit_clock16_i),
    .a_tx1_i   (chan_a_transmit_clock_i),
    .a_rx1_i   (chan_a_receive_clock_i),
    .b_tx1_i   (chan_b_transmit_clock_i),
    .b_rx1_i   (chan_b_receive_clock_i),
    .pins_o    (output_pins_o),
    .out2_o    (general_output_2_o),
    .out3_o    (general_output_3_o),
    .out3_oe_o (general_output_3_oe_o)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence stop_read_s;
    rd_stop && !ctr_terminal_i;
  endsequence

  sequence start_read_s;
    rd_start ##1 ctr_ctl_o.start;
  endsequence

  sequence enabled_change_s;
    (|(in_pulse & aux_ctrl_r[2:0]));
  endsequence

  cos_sets_a: assert property (enabled_change_s |=> flags_w[BIT_COS])
    else $error("enabled input change did not set flag");
  break_sets_a: assert property (chan_a_i.break_edge |=> brk_a_r)
    else $error("break edge did not set flag");
  rx_mirror_a: assert property (chan_b_i.full_select |-> flags_w[BIT_RX_B] == chan_b_i.fifo_full)
    else $error("receive status does not follow fifo full");
  tx_gate_a: assert property (!chan_a_i.transmit_ready |-> !tx_load_a_o)
    else $error("holding write passed while not ready");
  irq_follow_a: assert property ((|(flags_w & enables_r)) |=> irq_o)
    else $error("irq not raised for enabled flag");
  irq_quiet_a: assert property ((enables_r == REG_ZERO) ##1 (enables_r == REG_ZERO) |-> !irq_o)
    else $error("irq raised with all enables off");
  vector_reset_a: assert property ($past(rst_i) |-> irq_vector_o == VECTOR_RESET)
    else $error("vector not at reset value");
  pins_upper_a: assert property (rd_pins |=> cpu_rdata_o[5:3] == UPPER_INPUTS)
    else $error("upper input bits not one");
  pins_latch_a: assert property (rd_pins |=> cpu_rdata_o[2:0] == $past(general_inputs_i))
    else $error("input levels not latched at read");
  set_bits_a: assert property (wr_set |=> op_bits_r == ($past(op_bits_r) | $past(wbyte)))
    else $error("set command wrong");
  clear_bits_a: assert property (wr_clear |=> op_bits_r == ($past(op_bits_r) & ~$past(wbyte)))
    else $error("clear command wrong");
  pin_invert_a: assert property (##2 output_pins_o == ~$past(op_bits_r[1:0]))
    else $error("output pins not inverted");
  start_pulse_a: assert property (start_read_s |=> !ctr_ctl_o.start || $past(rd_start))
    else $error("start pulse too long");
  stop_clears_a: assert property (stop_read_s |=> !ctr_rdy_r ##0 ctr_ctl_o.stop)
    else $error("stop read did not clear ready");
  terminal_hold_a: assert property (ctr_terminal_i ##1 !rd_stop |=> ctr_rdy_r)
    else $error("ready not held after terminal count");

endmodule // serial_irq_counter_port_regs
`default_nettype wire

// >>> hdl/serial_regs_pkg.sv
// Contract
// - enabled input change sets input-change flag
// - break start or end sets break flag
// - receive status mirrors fifo-full or ready
// - transmit status mirrors channel transmit ready
// - holding writes ignored while transmit not ready
// - irq when flag and enable both set
// - one enable bit per interrupt source
// - preload bytes are write only
// - vector register eight bits, resets 0f
// - input pins latched when read
// - upper three input bits read one
// - out3 field selects output three source
// - output three open-drain for auxiliary functions
// - out2 field selects output two source
// - set command sets bits written one
// - clear command clears bits written one
// - output pins are inverted register bits
// - start read starts counter, data meaningless
// - stop read stops counter, clears ready
// - word or byte access, low byte valid
// - change register read clears change flags
// - reset clears sticky interrupt status bits; receive and transmit status follow the channels
package serial_regs_pkg;

  // read and write of each pair share an address, except the stop read and the output clear write
  localparam logic [31:0] OFS_CHANGE_AUX   = 32'hfffff7e9;
  localparam logic [31:0] OFS_FLAGS_ENABLE = 32'hfffff7eb;
  localparam logic [31:0] OFS_COUNT_HI     = 32'hfffff7ed;
  localparam logic [31:0] OFS_COUNT_LO     = 32'hfffff7ef;
  localparam logic [31:0] OFS_VECTOR       = 32'hfffff7f9;
  localparam logic [31:0] OFS_PINS_FUNC    = 32'hfffff7fb;
  localparam logic [31:0] OFS_START_SET    = 32'hfffff7fd;
  localparam logic [31:0] OFS_STOP         = 32'hfffff7ff;
  localparam logic [31:0] OFS_OUT_CLEAR    = 32'h0ffff7ff;

  localparam int unsigned BIT_COS   = 7;
  localparam int unsigned BIT_BRK_B = 6;
  localparam int unsigned BIT_RX_B  = 5;
  localparam int unsigned BIT_TX_B  = 4;
  localparam int unsigned BIT_CTR   = 3;
  localparam int unsigned BIT_BRK_A = 2;
  localparam int unsigned BIT_RX_A  = 1;
  localparam int unsigned BIT_TX_A  = 0;

  localparam int unsigned AUX_CTMS_LSB = 4;
  localparam int unsigned OUT3_FN_LSB  = 2;
  localparam int unsigned OUT2_FN_LSB  = 0;
  localparam int unsigned CHG_FLAG_LSB = 4;

  localparam logic [7:0] VECTOR_RESET  = 8'h0f;
  localparam logic [7:0] REG_ZERO      = 8'h00;
  localparam logic [2:0] UPPER_INPUTS  = 3'h7;
  localparam logic [1:0] PINS_IDLE     = 2'h3;

  localparam logic [1:0] FN3_REG  = 2'h0;
  localparam logic [1:0] FN3_CTR  = 2'h1;
  localparam logic [1:0] FN3_TXB1 = 2'h2;
  localparam logic [1:0] FN2_REG  = 2'h0;
  localparam logic [1:0] FN2_TXA16 = 2'h1;
  localparam logic [1:0] FN2_TXA1 = 2'h2;

  typedef struct packed {
    logic fifo_full;
    logic receive_ready;
    logic full_select;
    logic transmit_ready;
    logic holding_write;
    logic break_edge;
    logic break_clear;
  } chan_status_t;

  typedef struct packed {
    logic        start;
    logic        stop;
    logic [2:0]  mode_source;
    logic [15:0] preload;
  } counter_ctl_t;

endpackage

// >>> hdl/input_change_detect.sv
`timescale 1ns/1ns
`default_nettype none
module input_change_detect import serial_regs_pkg::*; #(
  parameter int unsigned N = 3
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // pins and clear
  input  wire logic [N-1:0] levels_i,
  input  wire logic         clear_i,
  // state
  output logic      [N-1:0] level_o,
  output logic      [N-1:0] change_o,
  output logic      [N-1:0] change_pulse_o
);

  if (N < 1 || N > 3) begin : g_bad_n
    $error("input_change_detect: N must be 1 to 3");
  end

  logic primed_r;

  // first sample after reset only primes, so a high pin is not a change
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      primed_r <= 1'b0;
      level_o  <= '0;
    end else begin
      primed_r <= 1'b1;
      level_o  <= levels_i;
    end
  end

  assign change_pulse_o = primed_r ? (levels_i ^ level_o) : '0;

  // new change wins over the clearing read
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      change_o <= '0;
    end else begin
      change_o <= (clear_i ? '0 : change_o) | change_pulse_o;
    end
  end

endmodule // input_change_detect
`default_nettype wire

// >>> hdl/out_port_drive.sv
`timescale 1ns/1ns
`default_nettype none
module out_port_drive import serial_regs_pkg::*; (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic [3:0] op_bits_i,
  input  wire logic [1:0] out3_fn_i,
  input  wire logic [1:0] out2_fn_i,
  // auxiliary sources
  input  wire logic       ctr_out_i,
  input  wire logic       a_tx16_i,
  input  wire logic       a_tx1_i,
  input  wire logic       a_rx1_i,
  input  wire logic       b_tx1_i,
  input  wire logic       b_rx1_i,
  // pins
  output logic      [1:0] pins_o,
  output logic            out2_o,
  output logic            out3_o,
  output logic            out3_oe_o
);

  logic aux3;

  always_comb begin
    case (out3_fn_i)
      FN3_CTR:  aux3 = ctr_out_i;
      FN3_TXB1: aux3 = b_tx1_i;
      default:  aux3 = b_rx1_i;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pins_o <= PINS_IDLE;
      out2_o <= 1'b1;
    end else begin
      pins_o <= ~op_bits_i[1:0];
      case (out2_fn_i)
        FN2_REG:   out2_o <= ~op_bits_i[2];
        FN2_TXA16: out2_o <= a_tx16_i;
        FN2_TXA1:  out2_o <= a_tx1_i;
        default:   out2_o <= a_rx1_i;
      endcase
    end
  end

  // auxiliary sources only pull low; the board pull-up gives the high level
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out3_o    <= 1'b1;
      out3_oe_o <= 1'b1;
    end else if (out3_fn_i == FN3_REG) begin
      out3_o    <= ~op_bits_i[3];
      out3_oe_o <= 1'b1;
    end else begin
      out3_o    <= 1'b0;
      out3_oe_o <= ~aux3;
    end
  end

endmodule // out_port_drive
`default_nettype wire

// >>> tb/test_serial_irq_counter_port_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_serial_irq_counter_port_regs import serial_regs_pkg::*;;
  logic         sys_clk_i, rst_i, cpu_rd_i, cpu_wr_i, ctr_terminal_i;
  logic [31:0]  cpu_addr_i;
  logic [15:0]  cpu_wdata_i, cpu_rdata_o, ctr_count_i, rd_val;
  chan_status_t chan_a_i, chan_b_i;
  counter_ctl_t ctr_ctl_o;
  logic [2:0]   src2, src3, general_inputs_i;
  logic [1:0]   output_pins_o;
  logic         tx_load_a_o, tx_load_b_o, general_output_2_o, general_output_3_o, general_output_3_oe_o, irq_o;
  logic [7:0]   irq_vector_o;
  logic         o2_hi;
  int           fail_count, checks_done, cycles, start_seen, stop_seen, f;

  serial_irq_counter_port_regs #(.INPUT_COUNT(3)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i),
    .cpu_wr_i(cpu_wr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
    .chan_a_i(chan_a_i), .chan_b_i(chan_b_i), .tx_load_a_o(tx_load_a_o), .tx_load_b_o(tx_load_b_o),
    .chan_a_transmit_clock16_i(src2[0]), .chan_a_transmit_clock_i(src2[1]),
    .chan_a_receive_clock_i(src2[2]), .chan_b_transmit_clock_i(src3[1]),
    .chan_b_receive_clock_i(src3[2]), .ctr_ctl_o(ctr_ctl_o), .ctr_count_i(ctr_count_i),
    .ctr_out_i(src3[0]), .ctr_terminal_i(ctr_terminal_i), .general_inputs_i(general_inputs_i),
    .output_pins_o(output_pins_o), .general_output_2_o(general_output_2_o),
    .general_output_3_o(general_output_3_o), .general_output_3_oe_o(general_output_3_oe_o),
    .irq_o(irq_o), .irq_vector_o(irq_vector_o));

  initial sys_clk_i = 1'h0;
  always #5 sys_clk_i = ~sys_clk_i;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // cycle ceiling: the whole sequence needs a few hundred cycles
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (ctr_ctl_o.start === 1'h1) start_seen++;
    if (ctr_ctl_o.stop === 1'h1) stop_seen++;
    if (cycles == 5000) begin
      fail_count++;
      $display("MISMATCH timeout expected end seen hang");
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    cpu_addr_i  <= a;
    cpu_wdata_i <= d;
    cpu_wr_i    <= 1'h1;
    @(posedge sys_clk_i);
    cpu_wr_i    <= 1'h0;
  endtask

  // read data is registered, so sample one full cycle after the taken edge
  task automatic rdc(input string n, input logic [31:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    cpu_addr_i <= a;
    cpu_rd_i   <= 1'h1;
    @(posedge sys_clk_i);
    cpu_rd_i   <= 1'h0;
    @(posedge sys_clk_i);
    #1;
    chk(n, {8'h00, e}, cpu_rdata_o);
  endtask

  task automatic flag_pulse(input int which);
    @(posedge sys_clk_i);
    if (which == 0) chan_b_i.break_edge <= 1'h1;
    else if (which == 1) chan_b_i.break_clear <= 1'h1;
    else ctr_terminal_i <= 1'h1;
    @(posedge sys_clk_i);
    chan_b_i.break_edge  <= 1'h0;
    chan_b_i.break_clear <= 1'h0;
    ctr_terminal_i       <= 1'h0;
    tick(3);
  endtask

  initial begin
    rst_i = 1'h1; cpu_addr_i = 32'h0; cpu_rd_i = 1'h0; cpu_wr_i = 1'h0; cpu_wdata_i = 16'h0;
    chan_a_i = '0; chan_b_i = '0; src2 = 3'h0; src3 = 3'h0; ctr_count_i = 16'h1234;
    ctr_terminal_i = 1'h0; general_inputs_i = 3'h0; fail_count = 0; checks_done = 0;
    cycles = 0; start_seen = 0; stop_seen = 0;
    tick(5);
    rst_i <= 1'h0;
    tick(2);
    chk("irq", 16'h0, {15'h0, irq_o});
    chk("pins", 16'h3, {14'h0, output_pins_o});
    chk("vector", 16'h0f, {8'h0, irq_vector_o});
    rdc("vector", OFS_VECTOR, 8'h0f);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h00);
    wr(OFS_VECTOR, 16'hab5a);
    wr(32'hfffff7f1, 16'h0055);
    rdc("vector", OFS_VECTOR, 8'h5a);
    rdc("unmapped", 32'hfffff7f1, 8'h00);
    $display("test reset_vector done");

    wr(OFS_CHANGE_AUX, 16'h0006);
    @(posedge sys_clk_i) general_inputs_i <= 3'h1;
    tick(4);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h00);
    rdc("change", OFS_CHANGE_AUX, 8'h11);
    @(posedge sys_clk_i) general_inputs_i <= 3'h3;
    tick(4);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h80);
    rdc("change", OFS_CHANGE_AUX, 8'h23);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h00);
    @(posedge sys_clk_i) general_inputs_i <= 3'h5;
    tick(2);
    rdc("inputs", OFS_PINS_FUNC, 8'h3d);
    rdc("change", OFS_CHANGE_AUX, 8'h65);
    $display("test input_change done");

    @(posedge sys_clk_i) begin
      chan_a_i.transmit_ready <= 1'h1;
      chan_b_i.transmit_ready <= 1'h1;
    end
    wr(OFS_FLAGS_ENABLE, 16'h00ee);
    tick(3);
    chk("irq", 16'h0, {15'h0, irq_o});
    rdc("flags", OFS_FLAGS_ENABLE, 8'h11);
    wr(OFS_FLAGS_ENABLE, 16'h0010);
    tick(3);
    chk("irq", 16'h1, {15'h0, irq_o});
    wr(OFS_FLAGS_ENABLE, 16'h0040);
    tick(3);
    chk("irq", 16'h0, {15'h0, irq_o});
    flag_pulse(0);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h51);
    chk("irq", 16'h1, {15'h0, irq_o});
    flag_pulse(1);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h11);
    @(posedge sys_clk_i) begin
      chan_a_i.full_select <= 1'h1;
      chan_a_i.fifo_full   <= 1'h1;
    end
    tick(3);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h13);
    @(posedge sys_clk_i) chan_a_i.full_select <= 1'h0;
    tick(3);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h11);
    @(posedge sys_clk_i) chan_a_i.transmit_ready <= 1'h0;
    tick(3);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h10);
    $display("test flags done");

    @(posedge sys_clk_i) chan_a_i.holding_write <= 1'h1;
    #1 chk("load", 16'h0, {15'h0, tx_load_a_o});
    @(posedge sys_clk_i) chan_a_i.holding_write <= 1'h0;
    @(posedge sys_clk_i) chan_b_i.holding_write <= 1'h1;
    #1 chk("load", 16'h1, {15'h0, tx_load_b_o});
    @(posedge sys_clk_i) chan_b_i.holding_write <= 1'h0;
    $display("test holding done");

    rdc("count hi", OFS_COUNT_HI, 8'h12);
    rdc("count lo", OFS_COUNT_LO, 8'h34);
    wr(OFS_COUNT_HI, 16'hff77);
    wr(OFS_COUNT_LO, 16'h0002);
    rdc("count hi", OFS_COUNT_HI, 8'h12);
    rdc("count lo", OFS_COUNT_LO, 8'h34);
    chk("preload", 16'h7702, ctr_ctl_o.preload);
    wr(OFS_FLAGS_ENABLE, 16'h0008);
    flag_pulse(2);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h18);
    chk("irq", 16'h1, {15'h0, irq_o});
    rdc("start", OFS_START_SET, 8'h00);
    chk("start", 16'h1, start_seen[15:0]);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h18);
    rdc("stop", OFS_STOP, 8'h00);
    chk("stop", 16'h1, stop_seen[15:0]);
    rdc("flags", OFS_FLAGS_ENABLE, 8'h10);
    tick(2);
    chk("irq", 16'h0, {15'h0, irq_o});
    $display("test counter done");

    wr(OFS_START_SET, 16'h000f);
    tick(3);
    chk("pins", 16'h0, {14'h0, output_pins_o});
    chk("out2", 16'h0, {15'h0, general_output_2_o});
    chk("out3", 16'h1, {14'h0, general_output_3_o, general_output_3_oe_o});
    wr(OFS_OUT_CLEAR, 16'h0005);
    tick(3);
    chk("pins", 16'h1, {14'h0, output_pins_o});
    chk("out2", 16'h1, {15'h0, general_output_2_o});
    // each auxiliary source is driven alone so a wrong route shows up
    for (f = 1; f < 4; f++) begin
      wr(OFS_PINS_FUNC, 16'(f * 5));
      @(posedge sys_clk_i) begin
        src2 <= 3'(1 << (f - 1));
        src3 <= 3'(1 << (f - 1));
      end
      tick(4);
      o2_hi = general_output_2_o;
      chk("out3 src1", 16'h0, {14'h0, general_output_3_o, general_output_3_oe_o});
      @(posedge sys_clk_i) begin
        src2 <= 3'h0;
        src3 <= 3'h0;
      end
      tick(4);
      chk("out2 follow", 16'h1, {15'h0, general_output_2_o ^ o2_hi});
      chk("out3 src0", 16'h1, {14'h0, general_output_3_o, general_output_3_oe_o});
    end
    $display("test outputs done");
    close_out();
  end
endmodule // test_serial_irq_counter_port_regs
`default_nettype wire
